// file: logic/pdc_pkg.sv
// Constants and helpers shared by the device configuration block
package pdc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET = 8'h40;
  localparam logic [31:0] CFG_RESET = 32'h0000_2100;
  localparam logic [31:0] CFG_WRITE_MASK = 32'hf9ff_ff80;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IRQ_EN_MSB = 31;
  localparam int IRQ_EN_DPR_BIT = 24;
  localparam int GLOBAL_IRQ_BIT = 23;
  localparam int EXT_WIDTH_LSB = 20;
  localparam int SPLIT_DIS_BIT = 19;
  localparam int ROM_WIDTH_LSB = 16;
  localparam int BYTE_LANE_BIT = 15;
  localparam int LAT_LINE_BIT = 14;
  localparam int MASTER_EN_BIT = 13;
  localparam int LINE_STOP_BIT = 12;
  localparam int LEVEL_LSB = 8;
  localparam int PLAIN_READ_BIT = 7;
  // ---------------------------------------------------------------
  // Counts and commands
  // ---------------------------------------------------------------
  localparam int LEVEL_UNIT_BYTES = 16;
  localparam int LEVEL_ZERO_BYTES = 256;
  localparam logic [3:0] SELECT_ZERO_CLOCKS = 4'h8;
  localparam logic [2:0] SELECT_MIN_CODE = 3'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
  localparam logic [3:0] ALL_LANES = 4'hf;

  // Select width in clocks; reserved codes take the zero-code width
  function automatic logic [3:0] pdc_select_clocks(input logic [2:0] code);
    if (code < SELECT_MIN_CODE) begin
      return SELECT_ZERO_CLOCKS;
    end
    return {1'b0, code};
  endfunction
endpackage

// file: logic/pdc_sel_if.sv
// Link between the configuration block and a chip-select timer
`timescale 1ns/1ps
interface pdc_sel_if;
  logic start;
  logic [2:0] widthCode;
  logic select;
  modport timer(input start, input widthCode, output select);
  modport ctrl(output start, output widthCode, input select);
endinterface

// file: logic/pdc_select_timer.sv
// Chip-select width timer for one external access target
`timescale 1ns/1ps
module pdc_select_timer (
  input wire logic clk,
  input wire logic reset,
  pdc_sel_if.timer port
);
  import pdc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_HOLD = 2'b10} pdc_sel_state_e;
  typedef struct packed {
    pdc_sel_state_e state;
    logic [3:0] count;
    logic [3:0] target;
    logic select;
  } pdc_sel_s;

  localparam pdc_sel_s SEL_RESET = '{ST_IDLE, 4'h0, 4'h0, 1'b0};

  pdc_sel_s q;
  pdc_sel_s d;
  logic [3:0] lenQ;

  // Count clock edges from the start of the access
  always_comb begin
    d = q;
    unique case (q.state)
      ST_IDLE: begin
        if (port.start) begin
          d.state = ST_HOLD;
          d.target = pdc_select_clocks(port.widthCode);
          d.count = 4'h1;
          d.select = 1'b1;
        end
      end
      ST_HOLD: begin
        if (q.count == q.target) begin
          d.state = ST_IDLE;
          d.select = 1'b0;
        end else begin
          d.count = q.count + 4'h1;
        end
      end
      default: d = SEL_RESET;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= SEL_RESET;
    end else begin
      q <= d;
    end
  end

  assign port.select = q.select;

  // Length of the current select pulse, for checking only
  always_ff @(posedge clk) begin
    if (reset) begin
      lenQ <= 4'h0;
    end else if (q.select) begin
      lenQ <= lenQ + 4'h1;
    end else begin
      lenQ <= 4'h0;
    end
  end

  a_select_length: assert property (@(posedge clk) disable iff (reset)
    $fell(port.select) |-> (lenQ == q.target) && (lenQ >= 4'h3) && (lenQ <= 4'h8))
    else $error("select pulse length differs from width code");
  a_select_start: assert property (@(posedge clk) disable iff (reset)
    (port.start && q.state == ST_IDLE) |=>
      port.select && (q.target == pdc_select_clocks($past(port.widthCode))))
    else $error("select not raised with decoded width");
endmodule

// file: logic/pdc_device_config.sv
// Device configuration register with interrupt, select and master control
`timescale 1ns/1ps
module pdc_device_config #(
  parameter int LINE_BYTES = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [3:0] regByteEn,
  input wire logic [31:0] regWData,
  output logic [31:0] regRData,
  output logic regReadValid,
  input wire logic [5:0] errEvent,
  input wire logic irqFlagClear,
  input wire logic otherIrqPending,
  output logic irqFlag,
  output logic intaOut,
  output logic intaOe,
  input wire logic extStart,
  input wire logic romStart,
  output logic extSelect,
  output logic romSelect,
  input wire logic cmdMasterEnable,
  input wire logic ioSpaceEnable,
  input wire logic memSpaceEnable,
  input wire logic dmaActive,
  input wire logic dmaRead,
  input wire logic [31:0] dmaAddr,
  input wire logic [15:0] dmaBytes,
  input wire logic [8:0] fifoBytes,
  input wire logic [8:0] fifoFree,
  input wire logic latencyExpired,
  input wire logic grant,
  input wire logic dmaParityStop,
  input wire logic masterAbortSeen,
  input wire logic targetAbortSeen,
  output logic busRequest,
  output logic [3:0] readCommand,
  output logic [3:0] byteEnFirst,
  output logic [3:0] byteEnLast,
  output logic writeLineStop,
  output logic writeInvalidateNext,
  output logic stopNow,
  output logic stopAtLine,
  output logic masterEnable
);
  import pdc_pkg::*;

  localparam int LINE_LOG = $clog2(LINE_BYTES);

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic rvalid;
    logic irqFlag;
    logic intaOe;
    logic busReq;
    logic [3:0] rdCmd;
    logic [3:0] beFirst;
    logic [3:0] beLast;
    logic wrLineStop;
    logic wrInvalidate;
    logic stopNow;
    logic stopAtLine;
  } pdc_cfg_s;

  localparam pdc_cfg_s CFG_STATE_RESET = '{CFG_RESET, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0,
    CMD_MEM_READ, ALL_LANES, ALL_LANES, 1'b0, 1'b0, 1'b0, 1'b0};

  pdc_cfg_s q;
  pdc_cfg_s d;
  logic [5:0] irqEn;
  logic [8:0] level;
  logic [16:0] lineEnd;
  logic [16:0] wordEnd;
  logic [1:0] endLane;
  logic [3:0] leadMask;
  logic [3:0] trailMask;
  logic hit;
  logic latencyHit;
  logic longWrite;

  // ---------------------------------------------------------------
  // Decoded fields and transfer geometry
  // ---------------------------------------------------------------
  assign irqEn = {q.cfg[IRQ_EN_MSB -: 5], q.cfg[IRQ_EN_DPR_BIT]};
  assign hit = (regAddr == CFG_OFFSET);
  assign level = (q.cfg[LEVEL_LSB +: 4] == 4'h0) ? 9'(LEVEL_ZERO_BYTES) :
    9'(int'(q.cfg[LEVEL_LSB +: 4]) * LEVEL_UNIT_BYTES);
  assign lineEnd = 17'(dmaAddr[LINE_LOG-1:0]) + 17'(dmaBytes);
  assign wordEnd = 17'(dmaAddr[1:0]) + 17'(dmaBytes);
  assign endLane = 2'(dmaAddr[1:0] + dmaBytes[1:0]);
  assign leadMask = 4'(ALL_LANES << dmaAddr[1:0]);
  assign trailMask = (endLane == 2'h0) ? ALL_LANES : 4'(ALL_LANES >> (3'h4 - {1'b0, endLane}));
  assign latencyHit = dmaActive && latencyExpired && !grant;
  assign longWrite = dmaActive && !dmaRead && (dmaBytes > 16'(LINE_BYTES));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // Byte-lane register write; reserved bits forced to zero
    if (regWrite && hit) begin
      for (int b = 0; b < 4; b++) begin
        if (regByteEn[b]) begin
          d.cfg[8*b +: 8] = regWData[8*b +: 8];
        end
      end
    end
    d.cfg = d.cfg & CFG_WRITE_MASK;
    // Hardware clear of master enable beats a software write
    if (dmaParityStop || (dmaActive && (masterAbortSeen || targetAbortSeen))) begin
      d.cfg[MASTER_EN_BIT] = 1'b0;
    end
    // Read answer, unmapped offsets read zero
    d.rvalid = regRead;
    d.rdata = (regRead && hit) ? (q.cfg & CFG_WRITE_MASK) : 32'h0;
    // Sticky error flag, a new event wins over the clear
    if (irqFlagClear) begin
      d.irqFlag = 1'b0;
    end
    if (|(errEvent & irqEn)) begin
      d.irqFlag = 1'b1;
    end
    // Interrupt pin drive
    d.intaOe = q.cfg[GLOBAL_IRQ_BIT] && (q.irqFlag || otherIrqPending);
    // Bus request against the programmed level
    d.busReq = dmaActive && q.cfg[MASTER_EN_BIT] && cmdMasterEnable &&
      (ioSpaceEnable || memSpaceEnable) &&
      (dmaRead ? (fifoBytes >= level) : (fifoFree >= level));
    // Read command choice
    if (q.cfg[PLAIN_READ_BIT] || dmaBytes <= 16'h4) begin
      d.rdCmd = CMD_MEM_READ;
    end else if (lineEnd > 17'(LINE_BYTES)) begin
      d.rdCmd = CMD_MEM_READ_MULT;
    end else begin
      d.rdCmd = CMD_MEM_READ_LINE;
    end
    // Leading and trailing byte lanes of a read
    if (dmaActive && dmaRead && q.cfg[BYTE_LANE_BIT]) begin
      d.beFirst = (wordEnd <= 17'h4) ? (leadMask & trailMask) : leadMask;
      d.beLast = (wordEnd <= 17'h4) ? (leadMask & trailMask) : trailMask;
    end else begin
      d.beFirst = ALL_LANES;
      d.beLast = ALL_LANES;
    end
    // Write burst ending at line boundaries
    d.wrInvalidate = longWrite && !q.cfg[SPLIT_DIS_BIT];
    d.wrLineStop = dmaActive && !dmaRead &&
      (q.cfg[LINE_STOP_BIT] || (longWrite && !q.cfg[SPLIT_DIS_BIT]));
    // Latency timer stop, at line only for cache reads
    d.stopAtLine = latencyHit && dmaRead && q.cfg[LAT_LINE_BIT] &&
      (q.rdCmd != CMD_MEM_READ);
    d.stopNow = latencyHit && !d.stopAtLine;
  end

  // State register, master enable resets to one
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= CFG_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Chip-select timers
  // ---------------------------------------------------------------
  pdc_sel_if selIf[2] ();
  logic [1:0] selStart;
  assign selStart = {romStart, extStart};

  // One timer per select target, width field per target
  for (genvar g = 0; g < 2; g++) begin : gSel
    localparam int WLSB = (g == 0) ? EXT_WIDTH_LSB : ROM_WIDTH_LSB;
    assign selIf[g].start = selStart[g];
    assign selIf[g].widthCode = q.cfg[WLSB +: 3];
    pdc_select_timer uTimer (
      .clk(clk),
      .reset(reset),
      .port(selIf[g])
    );
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regRData = q.rdata;
  assign regReadValid = q.rvalid;
  assign irqFlag = q.irqFlag;
  assign intaOut = 1'b0; // Open drain, only pulls low
  assign intaOe = q.intaOe;
  assign extSelect = selIf[0].select;
  assign romSelect = selIf[1].select;
  assign busRequest = q.busReq;
  assign readCommand = q.rdCmd;
  assign byteEnFirst = q.beFirst;
  assign byteEnLast = q.beLast;
  assign writeLineStop = q.wrLineStop;
  assign writeInvalidateNext = q.wrInvalidate;
  assign stopNow = q.stopNow;
  assign stopAtLine = q.stopAtLine;
  assign masterEnable = q.cfg[MASTER_EN_BIT];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_latency_hit;
    dmaActive && latencyExpired && !grant;
  endsequence
  sequence s_long_split_write;
    dmaActive && !dmaRead && (dmaBytes > 16'(LINE_BYTES)) && !q.cfg[SPLIT_DIS_BIT];
  endsequence

  a_irq_gate: assert property ($rose(irqFlag) |-> $past(|(errEvent & irqEn)))
    else $error("error flag set without an enabled event");
  a_inta_gate: assert property (intaOe |-> $past(q.cfg[GLOBAL_IRQ_BIT]))
    else $error("interrupt pin driven while globally disabled");
  a_reserved_zero: assert property (regReadValid |-> regRData[26:25] == 2'b00)
    else $error("reserved bits read nonzero");
  a_split_write: assert property (s_long_split_write |=> writeLineStop && writeInvalidateNext)
    else $error("long write not split at line");
  a_byte_all: assert property ((dmaActive && !q.cfg[BYTE_LANE_BIT]) |=>
    byteEnFirst == 4'hf && byteEnLast == 4'hf)
    else $error("byte lanes not all on");
  a_latency_end: assert property (s_latency_hit |=> (stopNow ^ stopAtLine))
    else $error("latency expiry did not end transfer");
  a_master_clear: assert property ((dmaParityStop ||
    (dmaActive && (masterAbortSeen || targetAbortSeen))) |=> !masterEnable)
    else $error("master enable not cleared on abort");
  a_line_stop: assert property ((dmaActive && !dmaRead && q.cfg[LINE_STOP_BIT])
    |=> writeLineStop)
    else $error("write not stopped at line");
  a_bus_req: assert property (busRequest |-> $past(cmdMasterEnable && dmaActive &&
    (dmaRead ? fifoBytes >= level : fifoFree >= level)))
    else $error("bus request without level reached");
  a_plain_read: assert property ((q.cfg[PLAIN_READ_BIT] || dmaBytes <= 16'h4)
    |=> readCommand == 4'h6)
    else $error("plain read command not used");
endmodule

// file: test/pdc_pci_host_model.sv
// Behavioural PCI host side: command enables, grant and latency timer
`timescale 1ns/1ps
module pdc_pci_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic hostOn,
  input wire logic revoke,
  input wire logic busRequest,
  output logic cmdMasterEnable,
  output logic ioSpaceEnable,
  output logic memSpaceEnable,
  output logic grant,
  output logic latencyExpired
);
  // Software enables mastering and memory space before expecting DMA
  always_ff @(posedge clk) begin
    cmdMasterEnable <= !reset && hostOn;
    memSpaceEnable <= !reset && hostOn;
    ioSpaceEnable <= 1'b0;
  end
  // Grant follows request; a revoke removes grant as the timer expires
  always_ff @(posedge clk) begin
    grant <= !reset && busRequest && !revoke;
    latencyExpired <= !reset && revoke;
  end
endmodule

// file: test/pdc_device_config_test.sv
// Self-checking bench for the device configuration block
`timescale 1ns/1ps
module pdc_device_config_test;
  import pdc_pkg::*;
  logic clk, reset, regWrite, regRead, regReadValid, irqFlagClear, otherIrqPending;
  logic [7:0] regAddr;
  logic [3:0] regByteEn, readCommand, byteEnFirst, byteEnLast;
  logic [31:0] regWData, regRData, dmaAddr;
  logic [5:0] errEvent;
  logic irqFlag, intaOut, intaOe, extStart, romStart, extSelect, romSelect;
  logic cmdMasterEnable, ioSpaceEnable, memSpaceEnable, dmaActive, dmaRead;
  logic [15:0] dmaBytes;
  logic [8:0] fifoBytes, fifoFree;
  logic latencyExpired, grant, dmaParityStop, masterAbortSeen, targetAbortSeen;
  logic busRequest, writeLineStop, writeInvalidateNext, stopNow, stopAtLine, masterEnable;
  logic hostOn, revoke;
  int error_cnt, n_checks;

  pdc_device_config #(.LINE_BYTES(32)) dut (.clk, .reset, .regWrite, .regRead, .regAddr,
    .regByteEn, .regWData, .regRData, .regReadValid, .errEvent, .irqFlagClear,
    .otherIrqPending, .irqFlag, .intaOut, .intaOe, .extStart, .romStart, .extSelect,
    .romSelect, .cmdMasterEnable, .ioSpaceEnable, .memSpaceEnable, .dmaActive, .dmaRead,
    .dmaAddr, .dmaBytes, .fifoBytes, .fifoFree, .latencyExpired, .grant, .dmaParityStop,
    .masterAbortSeen, .targetAbortSeen, .busRequest, .readCommand, .byteEnFirst,
    .byteEnLast, .writeLineStop, .writeInvalidateNext, .stopNow, .stopAtLine, .masterEnable);
  pdc_pci_host_model host (.clk, .reset, .hostOn, .revoke, .busRequest, .cmdMasterEnable,
    .ioSpaceEnable, .memSpaceEnable, .grant, .latencyExpired);

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Write held for one edge, taken at the edge where it drops
  task automatic reg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regByteEn <= be;
    regWData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] d);
    reg_wr(CFG_OFFSET, 4'hf, d);
  endtask
  // Read answer stands for the cycle after the taking edge
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check("regReadValid", regReadValid, 1);
    check("regRData", regRData, exp);
  endtask
  // Apply master inputs, then look once the registered outputs follow
  task automatic drive(input logic rd, input logic [31:0] a, input logic [15:0] n,
                       input logic [8:0] fb, ff);
    @(posedge clk);
    dmaActive <= 1'b1;
    dmaRead <= rd;
    dmaAddr <= a;
    dmaBytes <= n;
    fifoBytes <= fb;
    fifoFree <= ff;
    @(posedge clk);
    #1;
  endtask
  task automatic pulse_err(input logic [5:0] e, input logic clr);
    @(posedge clk);
    errEvent <= e;
    irqFlagClear <= clr;
    @(posedge clk);
    errEvent <= 6'h0;
    irqFlagClear <= 1'b0;
    #1;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_regs();
    reg_rd(CFG_OFFSET, CFG_RESET);
    check("masterEnable", masterEnable, 1);
    reg_rd(8'h44, 32'h0);
    reg_wr(8'h44, 4'hf, 32'h0);
    reg_rd(CFG_OFFSET, CFG_RESET);
    cfg(32'hffff_ffff);
    reg_rd(CFG_OFFSET, CFG_WRITE_MASK);
    reg_wr(CFG_OFFSET, 4'h8, 32'h0);
    reg_rd(CFG_OFFSET, CFG_WRITE_MASK & 32'h00ff_ffff);
  endtask
  // Each event sets the flag only under its own enable; pin needs global enable
  task automatic t_irq();
    int p;
    for (int i = 0; i < 6; i++) begin
      p = (i == 0) ? 24 : 26 + i;
      cfg(CFG_RESET | 32'h0080_0000 | (32'h1 << p));
      pulse_err(~(6'h1 << i), 1'b0);
      check("irqFlag", irqFlag, 0);
      pulse_err(6'h1 << i, i[0]); // Odd passes clear too: the set wins
      check("irqFlag", irqFlag, 1);
      @(posedge clk);
      #1;
      check("intaOe", intaOe, 1);
      pulse_err(6'h0, 1'b1);
    end
    cfg(CFG_RESET | 32'h8000_0000);
    otherIrqPending <= 1'b1;
    pulse_err(6'h20, 1'b0);
    @(posedge clk);
    #1;
    check("intaOe", intaOe, 0);
    cfg(CFG_RESET | 32'h0080_0000);
    @(posedge clk);
    #1;
    check("intaOe", intaOe, 1);
    check("intaOut", intaOut, 0);
    @(posedge clk);
    otherIrqPending <= 1'b0;
    pulse_err(6'h0, 1'b1);
    check("irqFlag", irqFlag, 0);
  endtask
  // Count select clocks for every code, reserved ones included
  task automatic t_select();
    logic [31:0] ne, nr;
    for (int c = 0; c < 8; c++) begin
      cfg(CFG_RESET | (32'(c) << EXT_WIDTH_LSB) | (32'(c) << ROM_WIDTH_LSB));
      @(posedge clk);
      extStart <= 1'b1;
      romStart <= 1'b1;
      @(posedge clk);
      extStart <= 1'b0;
      romStart <= 1'b0;
      ne = 0;
      nr = 0;
      for (int k = 0; k < 12; k++) begin
        #1;
        ne += extSelect;
        nr += romSelect;
        @(posedge clk);
      end
      check("extSelect clocks", ne, (c < 3) ? 8 : c);
      check("romSelect clocks", nr, (c < 3) ? 8 : c);
    end
  endtask
  // Request level at both sides of the threshold, reads and writes
  task automatic t_request();
    logic [8:0] lv;
    for (int c = 0; c < 16; c += 5) begin
      lv = (c == 0) ? 9'h100 : 9'(c * 16);
      cfg((CFG_RESET & ~32'hf00) | (32'(c) << LEVEL_LSB));
      drive(1'b1, 32'h0, 16'h4, lv - 9'h1, 9'h0);
      check("busRequest", busRequest, 0);
      drive(1'b1, 32'h0, 16'h4, lv, 9'h0);
      check("busRequest", busRequest, 1);
      drive(1'b0, 32'h0, 16'h4, 9'h0, lv);
      check("busRequest", busRequest, 1);
      drive(1'b0, 32'h0, 16'h4, lv, lv - 9'h1);
      check("busRequest", busRequest, 0);
    end
    @(posedge clk);
    hostOn <= 1'b0;
    drive(1'b0, 32'h0, 16'h4, 9'h0, 9'h100);
    check("busRequest", busRequest, 0);
    @(posedge clk);
    hostOn <= 1'b1;
  endtask
  task automatic rd_case(input logic [31:0] v, a, input logic [15:0] n,
                         input logic [3:0] cmd, bf, bl);
    cfg(v);
    drive(1'b1, a, n, 9'h0, 9'h0);
    check("readCommand", readCommand, cmd);
    check("byteEnFirst", byteEnFirst, bf);
    check("byteEnLast", byteEnLast, bl);
  endtask
  task automatic wr_case(input logic [31:0] v, input logic [15:0] n, input logic ls, inv);
    cfg(v);
    drive(1'b0, 32'h0, n, 9'h0, 9'h0);
    check("writeLineStop", writeLineStop, ls);
    check("writeInvalidateNext", writeInvalidateNext, inv);
  endtask
  // Revoke grant with the timer expired and see which stop is chosen
  task automatic lat_case(input logic [31:0] v, input logic sl, sn);
    cfg(v);
    drive(1'b1, 32'h0, 16'h40, 9'h0, 9'h0);
    @(posedge clk);
    revoke <= 1'b1;
    for (int k = 0; k < 6 && (stopNow | stopAtLine) !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("stopAtLine", stopAtLine, sl);
    check("stopNow", stopNow, sn);
    if ((stopNow | stopAtLine) !== 1'b1) begin
      print_verdict();
    end
    @(posedge clk);
    revoke <= 1'b0;
  endtask
  task automatic me_case(input logic [2:0] ev, input logic act, exp);
    cfg(CFG_RESET);
    @(posedge clk);
    dmaActive <= act;
    {dmaParityStop, masterAbortSeen, targetAbortSeen} <= ev;
    @(posedge clk);
    {dmaParityStop, masterAbortSeen, targetAbortSeen} <= 3'h0;
    #1;
    check("masterEnable", masterEnable, exp);
    reg_rd(CFG_OFFSET, exp ? CFG_RESET : CFG_RESET & ~32'h2000);
  endtask

  // Reset, then every scenario in turn
  initial begin
    {reset, hostOn} = 2'h3;
    {regWrite, regRead, irqFlagClear, otherIrqPending, extStart, romStart} = 6'h0;
    {dmaActive, dmaRead, dmaParityStop, masterAbortSeen, targetAbortSeen, revoke} = 6'h0;
    {regAddr, regByteEn, regWData, dmaAddr, errEvent} = 82'h0;
    {dmaBytes, fifoBytes, fifoFree} = 34'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_irq();
    t_select();
    t_request();
    rd_case(CFG_RESET | 32'h80, 32'h0, 16'h40, CMD_MEM_READ, ALL_LANES, ALL_LANES);
    rd_case(CFG_RESET, 32'h0, 16'h4, CMD_MEM_READ, ALL_LANES, ALL_LANES);
    rd_case(CFG_RESET, 32'h18, 16'h8, CMD_MEM_READ_LINE, ALL_LANES, ALL_LANES);
    rd_case(CFG_RESET, 32'h18, 16'h10, CMD_MEM_READ_MULT, ALL_LANES, ALL_LANES);
    rd_case(CFG_RESET | 32'h8000, 32'h1, 16'h2, CMD_MEM_READ, 4'h6, 4'h6);
    rd_case(CFG_RESET | 32'h8000, 32'h2, 16'h8, CMD_MEM_READ_LINE, 4'hc, 4'h3);
    wr_case(CFG_RESET, 16'h40, 1'b1, 1'b1);
    wr_case(CFG_RESET | 32'h8_0000, 16'h40, 1'b0, 1'b0);
    wr_case(CFG_RESET | 32'h8_1000, 16'h40, 1'b1, 1'b0);
    wr_case(CFG_RESET | 32'h1000, 16'h10, 1'b1, 1'b0);
    wr_case(CFG_RESET, 16'h10, 1'b0, 1'b0);
    lat_case(CFG_RESET | 32'h4000, 1'b1, 1'b0);
    lat_case(CFG_RESET | 32'h4080, 1'b0, 1'b1);
    lat_case(CFG_RESET, 1'b0, 1'b1);
    me_case(3'h4, 1'b0, 1'b0);
    me_case(3'h2, 1'b0, 1'b1);
    me_case(3'h2, 1'b1, 1'b0);
    me_case(3'h1, 1'b1, 1'b0);
    print_verdict();
  end
endmodule
